//--- include/pair_timer_pkg.sv
// Constants, field positions and carrier types for the pairable timer block.
// Assumes a single 200 MHz clock domain and a simple strobe register port.
package pair_timer_pkg;
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 32;
  // Base register offsets, one word each.
  localparam logic [7:0]  OFF_EVEN_CTRL  = 8'h00;
  localparam logic [7:0]  OFF_EVEN_COUNT = 8'h10;
  localparam logic [7:0]  OFF_EVEN_PER   = 8'h20;
  localparam logic [7:0]  OFF_ODD_CTRL   = 8'h30;
  localparam logic [7:0]  OFF_ODD_COUNT  = 8'h40;
  localparam logic [7:0]  OFF_ODD_PER    = 8'h50;
  localparam logic [7:0]  OFF_IRQ_STAT   = 8'h60;
  localparam logic [7:0]  OFF_IRQ_MASK   = 8'h70;
  // Alias selector in the low nibble of the address.
  localparam logic [3:0]  ALIAS_BASE     = 4'h0;
  localparam logic [3:0]  ALIAS_CLR      = 4'h4;
  localparam logic [3:0]  ALIAS_SET      = 4'h8;
  localparam logic [3:0]  ALIAS_INV      = 4'hC;
  // Control field positions.
  localparam int          BIT_ON         = 15;
  localparam int          BIT_IDLE_STOP  = 13;
  localparam int          BIT_GATE       = 7;
  localparam int          PS_LSB         = 4;
  localparam int          BIT_PAIR       = 3;
  localparam int          BIT_CLK_SRC    = 1;
  // Writable masks; every other bit is unimplemented.
  localparam logic [31:0] CTRL_MASK_EVEN = 32'h0000_A0FA;
  localparam logic [31:0] CTRL_MASK_ODD  = 32'h0000_A0F2;
  localparam logic [31:0] HALF_MASK      = 32'h0000_FFFF;
  localparam logic [31:0] IRQ_MASK_BITS  = 32'h0000_0003;
  localparam logic [15:0] PERIOD_RESET   = 16'hFFFF;
  localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;
  localparam int          IRQ_EVEN       = 0;
  localparam int          IRQ_ODD        = 1;
  localparam logic [7:0]  PS_MAX_COUNT   = 8'hFF;
  localparam logic [7:0]  PS_64_COUNT    = 8'h3F;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic       run;
    logic       idle_stop;
    logic       gated_accumulate;
    logic [2:0] prescale_select;
    logic       clock_source_select;
  } timer_cfg_t;
endpackage : pair_timer_pkg

//--- hw/timer_prescaler.sv
// Prescaler that turns qualified input edges into count ticks.
// Assumes the caller supplies a one-cycle source pulse and a clear.
`timescale 1ns/10ps
module timer_prescaler
  import pair_timer_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       ce_in,
  // Control
  input  wire logic       clear_in,
  input  wire logic       src_pulse_in,
  input  wire logic [2:0] sel_in,
  // Result
  output logic            tick_out
);
  logic [7:0] cnt_reg;
  logic [7:0] limit;
  logic       hit;

  assign limit = (sel_in == 3'b111) ? PS_MAX_COUNT :
                 (sel_in == 3'b110) ? PS_64_COUNT : 8'((8'h01 << sel_in) - 8'h01);
  assign hit      = src_pulse_in && (cnt_reg == limit);
  assign tick_out = hit;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_reg <= 8'h00;
    end else if (ce_in) begin
      if (clear_in || hit) begin
        cnt_reg <= 8'h00;
      end else if (src_pulse_in) begin
        cnt_reg <= cnt_reg + 8'h01;
      end
    end
  end
endmodule : timer_prescaler

//--- hw/timer_count_half.sv
// One 16-bit count and period pair; two of these form the wide timer.
// Assumes write strobes arrive already decoded and aliased.
`timescale 1ns/10ps
module timer_count_half
  import pair_timer_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        ce_in,
  // Software writes
  input  wire logic        cnt_wr_in,
  input  wire logic [15:0] cnt_wdata_in,
  input  wire logic        per_wr_in,
  input  wire logic [15:0] per_wdata_in,
  // Counting
  input  wire logic        inc_in,
  input  wire logic        wrap_in,
  // State
  output logic [15:0]      count_out,
  output logic [15:0]      period_out
);
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count_out  <= 16'h0000;
      period_out <= PERIOD_RESET;
    end else if (ce_in) begin
      if (per_wr_in) begin
        period_out <= per_wdata_in;
      end
      if (cnt_wr_in) begin
        count_out <= cnt_wdata_in;
      end else if (wrap_in) begin
        count_out <= 16'h0000;
      end else if (inc_in) begin
        count_out <= count_out + 16'h0001;
      end
    end
  end
endmodule : timer_count_half

//--- hw/pair_timer.sv
// Even/odd timer pair with prescalers, gating, idle stop, wide mode and aliases.
// Assumes synchronous inputs, a strobe register port and one 200 MHz clock.
//
// Notes on behaviour
// - Enable bit 15 runs the timer; zero holds it stopped.
// - Idle-stop bit 13 halts counting while the chip idles.
// - External clock source makes gate bit ignored and read as zero.
// - Internal source with gate set counts only while gate input high.
// - Prescale field bits 6-4 divides by 1,2,4,8,16,32,64,256.
// - Even timer pairing bit 3 joins both halves into 32 bits.
// - In wide mode all settings come from the even control register; the odd idle-stop bit still halts both halves here.
// - Pairing bit exists only on the even timer.
// - Upper sixteen and unimplemented bits read zero, writes ignored.
// - Clear, set, invert aliases sit 0x4, 0x8, 0xC above each register; writes to the status register aliases are ignored here.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
module pair_timer
  import pair_timer_pkg::*;
(
  // Clock, reset and enable
  input  wire logic                            clk_in,
  input  wire logic                            rst_b_in,
  input  wire logic                            ce_in,
  // Register port
  input  wire logic [pair_timer_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [pair_timer_pkg::DATA_W-1:0] wdata_in,
  input  wire logic                            wr_in,
  input  wire logic                            rd_in,
  output logic [pair_timer_pkg::DATA_W-1:0]    rdata_out,
  // Device status and pins
  input  wire logic                            idle_in,
  input  wire logic                            even_gate_in,
  input  wire logic                            odd_gate_in,
  input  wire logic                            even_ext_clk_in,
  input  wire logic                            odd_ext_clk_in,
  // Interrupt
  output logic                                 irq_out
);
  import pair_timer_pkg::*;

  reg_req_t   req;
  timer_cfg_t even_cfg;
  timer_cfg_t odd_cfg;
  logic [31:0] even_ctrl_reg;
  logic [31:0] odd_ctrl_reg;
  logic [31:0] stat_reg;
  logic [31:0] stat_next;
  logic [31:0] mask_reg;
  logic [31:0] rdata_next;
  logic        even_ext_d_reg;
  logic        odd_ext_d_reg;
  logic [15:0] even_count;
  logic [15:0] even_period;
  logic [15:0] odd_count;
  logic [15:0] odd_period;

  assign req = '{wr: wr_in, rd: rd_in, addr: addr_in, wdata: wdata_in};

  // Address decode: high nibble picks register, low nibble picks alias.
  wire [7:0] base_addr  = {req.addr[7:4], ALIAS_BASE};
  wire [3:0] alias_sel  = req.addr[3:0];
  wire       alias_ok   = (alias_sel == ALIAS_BASE) || (alias_sel == ALIAS_CLR) ||
                          (alias_sel == ALIAS_SET) || (alias_sel == ALIAS_INV);
  wire       hit_ectrl  = alias_ok && (base_addr == OFF_EVEN_CTRL);
  wire       hit_ecnt   = alias_ok && (base_addr == OFF_EVEN_COUNT);
  wire       hit_eper   = alias_ok && (base_addr == OFF_EVEN_PER);
  wire       hit_octrl  = alias_ok && (base_addr == OFF_ODD_CTRL);
  wire       hit_ocnt   = alias_ok && (base_addr == OFF_ODD_COUNT);
  wire       hit_oper   = alias_ok && (base_addr == OFF_ODD_PER);
  wire       hit_stat   = alias_ok && (base_addr == OFF_IRQ_STAT);
  wire       hit_mask   = alias_ok && (base_addr == OFF_IRQ_MASK);

  // alias selection; bit-wise clear, set and toggle.
  function automatic logic [31:0] apply_alias(input logic [31:0] cur, input logic [31:0] wd,
                                              input logic [3:0] sel, input logic [31:0] msk);
    logic [31:0] res;
    res = cur;
    case (sel)
      ALIAS_BASE: res = wd;
      ALIAS_CLR:  res = cur & ~wd;
      ALIAS_SET:  res = cur | wd;
      ALIAS_INV:  res = cur ^ wd;
      default:    res = cur;
    endcase
    return res & msk;
  endfunction : apply_alias

  // pairing bit exists only in the even mask.
  wire [31:0] ectrl_new = apply_alias(even_ctrl_reg, req.wdata, alias_sel, CTRL_MASK_EVEN);
  wire [31:0] octrl_new = apply_alias(odd_ctrl_reg, req.wdata, alias_sel, CTRL_MASK_ODD);
  wire [31:0] ecnt_new  = apply_alias({16'h0000, even_count}, req.wdata, alias_sel, HALF_MASK);
  wire [31:0] ocnt_new  = apply_alias({16'h0000, odd_count}, req.wdata, alias_sel, HALF_MASK);
  wire [31:0] eper_new  = apply_alias({16'h0000, even_period}, req.wdata, alias_sel, HALF_MASK);
  wire [31:0] oper_new  = apply_alias({16'h0000, odd_period}, req.wdata, alias_sel, HALF_MASK);
  wire [31:0] mask_new  = apply_alias(mask_reg, req.wdata, alias_sel, IRQ_MASK_BITS);

  // wide mode from the even pairing bit.
  wire wide = even_ctrl_reg[BIT_PAIR];

  assign even_cfg = '{run: even_ctrl_reg[BIT_ON], idle_stop: even_ctrl_reg[BIT_IDLE_STOP],
                      gated_accumulate: even_ctrl_reg[BIT_GATE],
                      prescale_select: even_ctrl_reg[PS_LSB+2:PS_LSB],
                      clock_source_select: even_ctrl_reg[BIT_CLK_SRC]};
  // odd settings replaced by even ones in wide mode, except odd idle-stop.
  assign odd_cfg  = wide ?
                    timer_cfg_t'{run: even_cfg.run, idle_stop: even_cfg.idle_stop | odd_ctrl_reg[BIT_IDLE_STOP],
                      gated_accumulate: even_cfg.gated_accumulate,
                      prescale_select: even_cfg.prescale_select,
                      clock_source_select: even_cfg.clock_source_select} :
                    timer_cfg_t'{run: odd_ctrl_reg[BIT_ON], idle_stop: odd_ctrl_reg[BIT_IDLE_STOP],
                      gated_accumulate: odd_ctrl_reg[BIT_GATE],
                      prescale_select: odd_ctrl_reg[PS_LSB+2:PS_LSB],
                      clock_source_select: odd_ctrl_reg[BIT_CLK_SRC]};

  // wide idle running also depends on the odd idle-stop bit being clear.
  wire even_idle_hold = idle_in && (even_cfg.idle_stop || (wide && odd_ctrl_reg[BIT_IDLE_STOP]));
  wire odd_idle_hold  = idle_in && odd_cfg.idle_stop;

  wire even_active = even_cfg.run && !even_idle_hold;
  wire odd_active  = odd_cfg.run && !odd_idle_hold;

  // external source: rising edge of the pin, gate ignored.
  // internal source gated by the gate pin when accumulation is on.
  wire even_src = even_cfg.clock_source_select ? (even_ext_clk_in && !even_ext_d_reg) :
                  (!even_cfg.gated_accumulate || even_gate_in);
  wire odd_src  = wide ? (even_cfg.clock_source_select ? (even_ext_clk_in && !even_ext_d_reg) :
                          (!even_cfg.gated_accumulate || even_gate_in)) :
                  (odd_cfg.clock_source_select ? (odd_ext_clk_in && !odd_ext_d_reg) :
                   (!odd_cfg.gated_accumulate || odd_gate_in));

  logic even_tick;
  logic odd_tick;

  timer_prescaler u_even_ps (
    .clk_in       (clk_in),
    .rst_b_in     (rst_b_in),
    .ce_in        (ce_in),
    .clear_in     (!even_active),
    .src_pulse_in (even_active && even_src),
    .sel_in       (even_cfg.prescale_select),
    .tick_out     (even_tick)
  );

  timer_prescaler u_odd_ps (
    .clk_in       (clk_in),
    .rst_b_in     (rst_b_in),
    .ce_in        (ce_in),
    .clear_in     (!odd_active || wide),
    .src_pulse_in (odd_active && odd_src && !wide),
    .sel_in       (odd_cfg.prescale_select),
    .tick_out     (odd_tick)
  );

  // compare and wrap; wide mode compares all 32 bits.
  wire wide_match = ({odd_count, even_count} == {odd_period, even_period});
  wire even_match = wide ? wide_match : (even_count == even_period);
  wire odd_match  = odd_count == odd_period;
  wire even_wrap  = even_tick && even_match;
  wire odd_wrap   = wide ? even_wrap : (odd_tick && odd_match);
  wire odd_inc    = wide ? (even_tick && (even_count == 16'hFFFF)) : odd_tick;

  // Software count writes take priority over counting for that cycle.
  wire wr_ecnt = req.wr && hit_ecnt;
  wire wr_ocnt = req.wr && hit_ocnt;

  timer_count_half u_even_half (
    .clk_in       (clk_in),
    .rst_b_in     (rst_b_in),
    .ce_in        (ce_in),
    .cnt_wr_in    (wr_ecnt),
    .cnt_wdata_in (ecnt_new[15:0]),
    .per_wr_in    (req.wr && hit_eper),
    .per_wdata_in (eper_new[15:0]),
    .inc_in       (even_tick),
    .wrap_in      (even_wrap),
    .count_out    (even_count),
    .period_out   (even_period)
  );

  timer_count_half u_odd_half (
    .clk_in       (clk_in),
    .rst_b_in     (rst_b_in),
    .ce_in        (ce_in),
    .cnt_wr_in    (wr_ocnt),
    .cnt_wdata_in (ocnt_new[15:0]),
    .per_wr_in    (req.wr && hit_oper),
    .per_wdata_in (oper_new[15:0]),
    .inc_in       (odd_inc),
    .wrap_in      (odd_wrap),
    .count_out    (odd_count),
    .period_out   (odd_period)
  );

  // Status: hardware set wins over a write-one clear in the same cycle.
  wire [31:0] evt_set   = {30'h0, odd_wrap && !wide, even_wrap};
  wire [31:0] stat_clr  = (req.wr && hit_stat && alias_sel == ALIAS_BASE) ? req.wdata : ZERO_WORD;
  assign stat_next = ((stat_reg & ~stat_clr) | evt_set) & IRQ_MASK_BITS;

  // gate bit reads zero under external source; upper bits read zero.
  wire [31:0] ectrl_view = even_ctrl_reg &
                           ~(even_ctrl_reg[BIT_CLK_SRC] ? (32'h1 << BIT_GATE) : ZERO_WORD);
  wire [31:0] octrl_view = odd_ctrl_reg &
                           ~(odd_ctrl_reg[BIT_CLK_SRC] ? (32'h1 << BIT_GATE) : ZERO_WORD);

  // Unmapped and alias addresses read as zero.
  wire base_rd = req.rd && (alias_sel == ALIAS_BASE);
  assign rdata_next = !base_rd  ? ZERO_WORD :
                      hit_ectrl ? ectrl_view :
                      hit_ecnt  ? {16'h0000, even_count} :
                      hit_eper  ? {16'h0000, even_period} :
                      hit_octrl ? octrl_view :
                      hit_ocnt  ? {16'h0000, odd_count} :
                      hit_oper  ? {16'h0000, odd_period} :
                      hit_stat  ? stat_reg :
                      hit_mask  ? mask_reg : ZERO_WORD;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      even_ctrl_reg   <= ZERO_WORD;
      odd_ctrl_reg    <= ZERO_WORD;
      stat_reg        <= ZERO_WORD;
      mask_reg        <= ZERO_WORD;
      rdata_out       <= ZERO_WORD;
      irq_out         <= 1'b0;
      even_ext_d_reg  <= 1'b0;
      odd_ext_d_reg   <= 1'b0;
    end else if (ce_in) begin
      if (req.wr && hit_ectrl) begin
        even_ctrl_reg <= ectrl_new;
      end
      if (req.wr && hit_octrl) begin
        odd_ctrl_reg <= octrl_new;
      end
      if (req.wr && hit_mask) begin
        mask_reg <= mask_new;
      end
      stat_reg        <= stat_next;
      rdata_out       <= rdata_next;
      irq_out         <= |(stat_next & mask_reg);
      even_ext_d_reg  <= even_ext_clk_in;
      odd_ext_d_reg   <= odd_ext_clk_in;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  chk_disabled_hold: assert property (ce_in && !even_cfg.run && !wr_ecnt |=> $stable(even_count))
    else $error("Even count moved while disabled.");
  chk_idle_halt: assert property (ce_in && idle_in && even_cfg.idle_stop && !wr_ecnt |=> $stable(even_count))
    else $error("Even count moved in idle with idle stop.");
  chk_gate_readzero: assert property (rd_in && addr_in == OFF_EVEN_CTRL && even_ctrl_reg[BIT_CLK_SRC] && ce_in
                                      |=> rdata_out[BIT_GATE] == 1'b0)
    else $error("Gate bit visible under external source.");
  chk_gate_blocks: assert property (ce_in && even_active && !even_cfg.clock_source_select
                                    && even_cfg.gated_accumulate && !even_gate_in |-> !even_tick)
    else $error("Tick while gate low.");
  chk_ps_full: assert property (ce_in && even_cfg.prescale_select == 3'b000 && even_active && even_src
                                |-> even_tick)
    else $error("One to one prescale missed a tick.");
  chk_odd_pair_zero: assert property (rd_in && ce_in && addr_in == OFF_ODD_CTRL |=> rdata_out[BIT_PAIR] == 1'b0)
    else $error("Odd pairing bit read as one.");
  chk_upper_zero: assert property (rd_in && ce_in && addr_in == OFF_EVEN_CTRL |=> rdata_out[31:16] == 16'h0000)
    else $error("Upper control bits not zero.");
  chk_wrap_flag: assert property (ce_in && even_wrap && !wr_ecnt |=> even_count == 16'h0000 && stat_reg[IRQ_EVEN])
    else $error("Wrap did not clear count or set flag.");
  chk_wide_carry: assert property (ce_in && wide && even_tick && even_count == 16'hFFFF && !even_wrap && !wr_ocnt
                                   |=> odd_count == $past(odd_count) + 16'h0001)
    else $error("Wide carry into odd half missed.");
  chk_set_alias: assert property (ce_in && wr_in && addr_in == (OFF_IRQ_MASK | ALIAS_SET)
                                  |=> (mask_reg & ($past(wdata_in) & IRQ_MASK_BITS)) == ($past(wdata_in) & IRQ_MASK_BITS))
    else $error("Set alias did not set bits.");
  chk_wide_oddcfg: assert property (wide |-> odd_cfg.prescale_select == even_cfg.prescale_select && odd_cfg.run == even_cfg.run)
    else $error("Odd settings not taken from even in wide mode.");

  cov_even_wrap: cover property (even_wrap);
  cov_wide_wrap: cover property (wide && even_wrap);
  cov_gated: cover property (even_cfg.gated_accumulate && even_tick);
  cov_irq: cover property (irq_out);
endmodule : pair_timer

//--- tb/test_pair_timer.sv
// Self-checking bench for the pairable timer block: register rows, reset, counting, idle, gate, wide mode, interrupt.
// Assumes the timer package is compiled first; the bench drives every port itself.
`timescale 1ns/10ps
module test_pair_timer;
  import pair_timer_pkg::*;
  typedef struct packed {
    logic [7:0]  wa;
    logic [31:0] wd;
    logic [7:0]  ra;
    logic [31:0] ex;
  } row_t;
  logic        clk_in;
  logic        rst_b_in;
  logic        ce_in;
  logic [7:0]  addr_in;
  logic [31:0] wdata_in;
  logic        wr_in;
  logic        rd_in;
  logic [31:0] rdata_out;
  logic        idle_in;
  logic        even_gate_in;
  logic        even_ext_clk_in;
  logic        irq_out;
  logic [31:0] got;
  logic [31:0] held;
  int          n_fail;
  int          n_checks;
  row_t        rows [12];

  pair_timer pair_timer_inst (
    .clk_in          (clk_in),
    .rst_b_in        (rst_b_in),
    .ce_in           (ce_in),
    .addr_in         (addr_in),
    .wdata_in        (wdata_in),
    .wr_in           (wr_in),
    .rd_in           (rd_in),
    .rdata_out       (rdata_out),
    .idle_in         (idle_in),
    .even_gate_in    (even_gate_in),
    .odd_gate_in     (1'b0),
    .even_ext_clk_in (even_ext_clk_in),
    .odd_ext_clk_in  (1'b0),
    .irq_out         (irq_out)
  );

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so it is taken just after that edge.
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    got = rdata_out;
  endtask : rd

  // Start latency is the designer's, so the count is accepted in a small window around the ideal.
  task automatic run(input logic [31:0] c, input int n, input logic [31:0] e);
    wr(8'h10, ZERO_WORD);
    wr(8'h00, c);
    repeat (n) @(posedge clk_in);
    wr(8'h00, ZERO_WORD);
    rd(8'h10);
    chk({31'h0, (got + 32'h1 >= e) && (got <= e + 32'h5)}, 32'h0000_0001);
  endtask : run

  initial begin
    repeat (40000) @(posedge clk_in);
    n_fail++;
    complete_run();
  end

  initial begin
    rst_b_in = 1'b0;
    ce_in = 1'b1;
    addr_in = 8'h00;
    wdata_in = ZERO_WORD;
    wr_in = 1'b0;
    rd_in = 1'b0;
    idle_in = 1'b0;
    even_gate_in = 1'b0;
    even_ext_clk_in = 1'b0;
    n_fail = 0;
    n_checks = 0;
    rows = '{'{8'h20, 32'h1234_5678, 8'h20, 32'h0000_5678}, '{8'h24, 32'h0000_0070, 8'h20, 32'h0000_5608},
             '{8'h28, 32'h0000_0003, 8'h20, 32'h0000_560B}, '{8'h2C, 32'h0000_FFFF, 8'h20, 32'h0000_A9F4},
             '{8'h22, 32'h0000_FFFF, 8'h20, 32'h0000_A9F4}, '{8'h28, ZERO_WORD, 8'h28, ZERO_WORD},
             '{8'h80, 32'hFFFF_FFFF, 8'h80, ZERO_WORD}, '{8'h00, 32'hFFFF_FFFF, 8'h00, 32'h0000_A07A},
             '{8'h30, 32'hFFFF_FFFF, 8'h30, 32'h0000_A072}, '{8'h04, 32'h0000_0002, 8'h00, 32'h0000_A0F8},
             '{8'h04, 32'hFFFF_FFFF, 8'h00, ZERO_WORD}, '{8'h34, 32'hFFFF_FFFF, 8'h30, ZERO_WORD}};
    repeat (5) @(posedge clk_in);
    rst_b_in <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd);
      rd(rows[i].ra);
      chk(got, rows[i].ex);
    end
    @(posedge clk_in);
    rst_b_in <= 1'b0;
    @(posedge clk_in);
    rst_b_in <= 1'b1;
    #1;
    chk({31'h0, irq_out}, ZERO_WORD);
    rd(8'h00);
    chk(got, ZERO_WORD);
    rd(8'h20);
    chk(got, {16'h0000, PERIOD_RESET});
    rd(8'h30);
    chk(got, ZERO_WORD);
    rd(8'h70);
    chk(got, ZERO_WORD);
    for (int p = 0; p < 8; p++) begin
      run(32'h0000_8000 | (p << PS_LSB), 1024, 32'(1024 >> ((p == 7) ? 8 : p)));
    end
    held = got;
    repeat (20) @(posedge clk_in);
    rd(8'h10);
    chk(got, held);
    idle_in <= 1'b1;
    run(32'h0000_A000, 64, 32'h0000_0000);
    run(32'h0000_8000, 64, 32'h0000_0040);
    idle_in <= 1'b0;
    run(32'h0000_8080, 64, 32'h0000_0000);
    run(32'h0000_8000, 64, 32'h0000_0040);
    even_gate_in <= 1'b1;
    run(32'h0000_8080, 64, 32'h0000_0040);
    even_gate_in <= 1'b0;
    // external edges counted while the gate is set but low.
    wr(8'h10, ZERO_WORD);
    wr(8'h00, 32'h0000_8082);
    for (int k = 0; k < 10; k++) begin
      repeat (2) @(posedge clk_in);
      even_ext_clk_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      even_ext_clk_in <= 1'b0;
    end
    repeat (4) @(posedge clk_in);
    wr(8'h00, ZERO_WORD);
    rd(8'h10);
    chk(got, 32'h0000_000A);
    // wrap at a short period raises the masked-in flag.
    wr(8'h20, 32'h0000_0003);
    wr(8'h70, 32'h0000_0001);
    wr(8'h10, ZERO_WORD);
    wr(8'h00, 32'h0000_8000);
    repeat (12) @(posedge clk_in);
    wr(8'h00, ZERO_WORD);
    #1;
    chk({31'h0, irq_out}, 32'h0000_0001);
    rd(8'h10);
    chk({31'h0, got <= 32'h0000_0003}, 32'h0000_0001);
    rd(8'h60);
    chk(got, 32'h0000_0001);
    wr(8'h60, 32'h0000_0001);
    repeat (2) @(posedge clk_in);
    chk({31'h0, irq_out}, ZERO_WORD);
    wr(8'h70, ZERO_WORD);
    wr(8'h00, 32'h0000_8000);
    repeat (12) @(posedge clk_in);
    wr(8'h00, ZERO_WORD);
    repeat (2) @(posedge clk_in);
    chk({31'h0, irq_out}, ZERO_WORD);
    wr(8'h78, 32'h0000_0001);
    repeat (2) @(posedge clk_in);
    chk({31'h0, irq_out}, 32'h0000_0001);
    wr(8'h60, 32'h0000_0003);
    // carry into the odd half only when paired.
    wr(8'h20, 32'h0000_FFFF);
    for (int w = 0; w < 2; w++) begin
      wr(8'h10, 32'h0000_FFFE);
      wr(8'h40, ZERO_WORD);
      wr(8'h00, (w == 1) ? 32'h0000_8008 : 32'h0000_8000);
      wr(8'h30, (w == 1) ? 32'h0000_8070 : ZERO_WORD);
      repeat (8) @(posedge clk_in);
      wr(8'h30, ZERO_WORD);
      wr(8'h00, ZERO_WORD);
      rd(8'h40);
      chk(got, 32'(w));
    end
    // clock enable low freezes counting; three enabled edges remain.
    wr(8'h20, 32'h0000_FFFF);
    wr(8'h10, ZERO_WORD);
    wr(8'h00, 32'h0000_8000);
    @(posedge clk_in);
    ce_in <= 1'b0;
    repeat (20) @(posedge clk_in);
    ce_in <= 1'b1;
    wr(8'h00, ZERO_WORD);
    rd(8'h10);
    chk(got, 32'h0000_0003);
    @(posedge clk_in);
    #1;
    chk(rdata_out, ZERO_WORD);
    complete_run();
  end
endmodule : test_pair_timer
